/* File: dv/boot_host_model.sv */
// host side of the uart link: sends image words as bytes
// assumes the bench calls send; bytes change 1 ns after a rising edge
`default_nettype none
module boot_host_model (
  // clock
  input  wire logic       i_clk,
  // byte stream toward the loader
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle cycles between bytes, 0 for back to back
  int gap = 0;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_byte  = 8'h00;
  end
  // 8n1 framing assumed done by the uart
  task automatic send(input logic [31:0] w);
    for (int i = 3; i >= 0; i--) begin
      o_rx_valid = 1'b1;
      o_rx_byte  = w[i*8 +: 8];
      @(posedge i_clk);
      #1;
      if (gap != 0) begin
        quiet();
        repeat (gap) @(posedge i_clk);
        #1;
      end
    end
  endtask : send
  // stale byte inverted so an idle line never looks valid
  task automatic quiet;
    if (o_rx_valid) begin
      o_rx_valid = 1'b0;
      o_rx_byte  = ~o_rx_byte;
    end
  endtask : quiet
endmodule : boot_host_model
`default_nettype wire

/* File: dv/boot_image_loader_assertions.sv */
// port checker for the boot image loader
// assumes one clock domain; bound at the foot of this file
`default_nettype none
module boot_image_loader_assertions
  import boot_loader_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  input wire logic        i_rx_valid,
  input wire logic        i_flash_ack,
  input wire logic        o_flash_req,
  input wire logic [1:0]  o_flash_pin_oe_n,
  input wire logic        o_tx_valid,
  input wire logic [7:0]  o_tx_byte,
  input wire ram_write_t  o_ram_wr,
  input wire logic [2:0]  o_boot_led,
  input wire logic        o_launch,
  input wire logic [31:0] o_launch_addr
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  addr_err_led_a: assert property (
    o_tx_valid && o_tx_byte == ERR_ADDR_BYTE |-> o_boot_led == LED_BAD_ADDR)
    else $error("address error without its led code");
  len_err_led_a: assert property (
    o_tx_valid && o_tx_byte == ERR_LEN_BYTE |-> o_boot_led == LED_BAD_LEN)
    else $error("length error without its led code");
  sum_err_led_a: assert property (
    o_tx_valid && o_tx_byte == ERR_SUM_BYTE |-> o_boot_led == LED_BAD_SUM)
    else $error("checksum error without its led code");
  tx_cause_a: assert property (
    o_tx_valid |-> $past(i_rx_valid))
    else $error("error byte not caused by a received byte");
  launch_hold_a: assert property (
    o_launch |=> o_launch && $stable(o_launch_addr))
    else $error("launch dropped or target moved");
  launch_range_a: assert property (
    o_launch |-> o_launch_addr >= RAM_LO && o_launch_addr <= RAM_HI)
    else $error("launch target outside sync ram");
  ram_range_a: assert property (
    o_ram_wr.valid |-> o_ram_wr.addr >= RAM_LO && o_ram_wr.addr <= RAM_HI)
    else $error("ram write outside sync ram");
  wr_cause_a: assert property (
    o_ram_wr.valid |-> $past(i_rx_valid) || $past(i_flash_ack))
    else $error("ram write without incoming data");
  flash_drive_a: assert property (
    o_flash_req |-> o_flash_pin_oe_n == 2'h0)
    else $error("flash request while flash pins are inputs");
endmodule : boot_image_loader_assertions
bind boot_image_loader boot_image_loader_assertions chk (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_rx_valid(i_rx_valid),
  .i_flash_ack(i_flash_ack), .o_flash_req(o_flash_req),
  .o_flash_pin_oe_n(o_flash_pin_oe_n), .o_tx_valid(o_tx_valid),
  .o_tx_byte(o_tx_byte), .o_ram_wr(o_ram_wr), .o_boot_led(o_boot_led),
  .o_launch(o_launch), .o_launch_addr(o_launch_addr));
`default_nettype wire

/* File: dv/boot_image_loader_tb.sv */
// self-checking bench for the boot image loader
// assumes the host model feeds bytes; the bench answers flash fetches
`default_nettype none
module boot_image_loader_tb
  import boot_loader_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk = 1'b0;
  logic        i_arst_n = 1'b0;
  logic [4:0]  i_strap = 5'h04;
  logic [1:0]  i_flash_pin_in = 2'h3;
  logic        flash_ack = 1'b0;
  logic [31:0] flash_data = 32'h0000_0000;
  logic        rx_valid, flash_req, tx_valid, launch, upd_en;
  logic [7:0]  rx_byte, tx_byte, tx_last;
  logic [1:0]  pin_out, oe_n;
  logic [31:0] flash_addr, launch_addr;
  logic [2:0]  led;
  ram_write_t  ram_wr;
  logic [63:0] wr_q[$];
  int          tx_n, num_errors, tests_run;
  always #25 i_clk = ~i_clk;
  boot_image_loader uut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_strap(i_strap),
    .i_flash_pin_in(i_flash_pin_in), .o_flash_pin_out(pin_out),
    .o_flash_pin_oe_n(oe_n), .o_flash_req(flash_req),
    .o_flash_addr(flash_addr), .i_flash_ack(flash_ack),
    .i_flash_data(flash_data), .i_rx_valid(rx_valid),
    .i_rx_byte(rx_byte), .o_tx_valid(tx_valid), .o_tx_byte(tx_byte),
    .o_ram_wr(ram_wr), .o_boot_led(led), .o_launch(launch),
    .o_launch_addr(launch_addr), .o_code_update_en(upd_en));
  boot_host_model host (
    .i_clk(i_clk), .o_rx_valid(rx_valid), .o_rx_byte(rx_byte));
  // sampled mid-cycle, well away from the launching edge
  always @(negedge i_clk) begin
    if (ram_wr.valid === 1'b1) begin
      wr_q.push_back({ram_wr.addr, ram_wr.data});
    end
    if (tx_valid === 1'b1) begin
      tx_last = tx_byte;
      tx_n++;
    end
  end
  function automatic logic differs(input logic [63:0] got,
                                   input logic [63:0] exp);
    tests_run++;
    return got !== exp;
  endfunction : differs
  task automatic fail(input string msg);
    num_errors++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask : fail
  task automatic settle;
    repeat (3) @(posedge i_clk);
    #1;
  endtask : settle
  task automatic boot(input logic [4:0] s, input logic [1:0] p);
    i_arst_n = 1'b0;
    i_strap = s;
    i_flash_pin_in = p;
    repeat (4) @(posedge i_clk);
    #1;
    if (differs(oe_n, 2'h3)) fail("pins driven in reset");
    wr_q.delete();
    tx_n = 0;
    i_arst_n = 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
  endtask : boot
  task automatic hdr(input logic [31:0] a, input logic [31:0] n);
    host.send(a);
    host.send(n);
  endtask : hdr
  task automatic t_uart_ok;
    boot(5'h04, 2'h3);
    hdr(32'h0203_FFF8, 32'h0000_0002);
    host.send(32'hFFFF_FFFF);
    host.send(32'h0000_0002);
    host.send(32'h0000_0001);
    host.quiet;
    settle;
    if (differs(launch, 1'b1)) fail("no launch");
    if (differs(launch_addr, 32'h0203_FFF8)) fail("launch target");
    if (differs(led, LED_OK)) fail("led code");
    if (differs(upd_en, 1'b1)) fail("update off");
    if (differs(wr_q.size(), 2)) fail("write count");
    if (differs(wr_q[0], 64'h0203_FFF8_FFFF_FFFF)) fail("word 0");
    if (differs(wr_q[1], 64'h0203_FFFC_0000_0002)) fail("word 1");
  endtask : t_uart_ok
  task automatic t_bad_len;
    boot(5'h04, 2'h3);
    hdr(RAM_LO, 32'h0000_0000);
    host.quiet;
    settle;
    if (differs(tx_last, ERR_LEN_BYTE)) fail("no length error");
    if (differs(led, LED_BAD_LEN)) fail("led code");
    hdr(RAM_LO, MAX_WORDS + 32'h0000_0001);
    host.quiet;
    settle;
    if (differs(tx_n, 2)) fail("error count");
    if (differs(launch, 1'b0)) fail("launched");
    hdr(RAM_LO, 32'h0000_0001);
    host.send(32'h1234_5678);
    host.send(32'h1234_5678);
    host.quiet;
    settle;
    if (differs(launch, 1'b1)) fail("no launch after restart");
    if (differs(launch_addr, RAM_LO)) fail("launch target");
  endtask : t_bad_len
  task automatic t_bad_sum;
    boot(5'h04, 2'h3);
    host.gap = 2;
    hdr(RAM_LO, 32'h0000_0001);
    host.send(32'h0000_0005);
    host.send(32'h0000_0006);
    host.quiet;
    settle;
    host.gap = 0;
    if (differs(tx_last, ERR_SUM_BYTE)) fail("no sum error");
    if (differs(led, LED_BAD_SUM)) fail("led code");
    if (differs(launch, 1'b0)) fail("launched");
    hdr(RAM_LO, 32'h0000_0001);
    host.send(32'h0000_0005);
    host.send(32'h0000_0005);
    host.quiet;
    settle;
    if (differs(launch, 1'b1)) fail("no launch");
    if (differs(led, LED_OK)) fail("led code");
  endtask : t_bad_sum
  task automatic t_bad_addr;
    boot(5'h04, 2'h3);
    host.send(32'h0204_0000);
    host.quiet;
    settle;
    if (differs(tx_last, ERR_ADDR_BYTE)) fail("no address error");
    if (differs(led, LED_BAD_ADDR)) fail("led code");
    host.send(32'h0201_FFFC);
    host.quiet;
    settle;
    if (differs(tx_n, 2)) fail("error count");
  endtask : t_bad_addr
  task automatic t_straps;
    boot(5'h00, 2'h3);
    settle;
    if (differs(led, LED_NO_UART)) fail("led code");
    if (differs(upd_en, 1'b0)) fail("update on");
    boot(5'h06, 2'h1);
    settle;
    if (differs(led, LED_NO_FLASH)) fail("led code");
    if (differs(flash_req, 1'b0)) fail("flash fetch");
    if (differs(oe_n, 2'h3)) fail("pins driven");
  endtask : t_straps
  // flash start, location then first word
  task automatic t_flash;
    boot(5'h02, 2'h3);
    settle;
    if (differs(flash_req, 1'b1)) fail("no fetch");
    if (differs(flash_addr, IMG_LOC_ADDR)) fail("loc addr");
    if (differs(oe_n, 2'h0)) fail("pins not driven");
    if (differs(pin_out, 2'h0)) fail("pin level");
    flash_ack = 1'b1;
    flash_data = 32'h0000_1000;
    @(posedge i_clk);
    #1;
    if (differs(flash_addr, 32'h0000_1000)) fail("image addr");
    flash_data = 32'hA5A5_0001;
    @(posedge i_clk);
    #1;
    flash_ack = 1'b0;
    settle;
    if (differs(wr_q.size(), 1)) fail("write count");
    if (differs(wr_q[0], {RAM_LO, 32'hA5A5_0001})) fail("word 0");
    if (differs(flash_addr, 32'h0000_1004)) fail("next addr");
  endtask : t_flash
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  initial begin
    t_uart_ok;
    t_bad_len;
    t_bad_sum;
    t_bad_addr;
    t_straps;
    t_flash;
    report_and_stop;
  end
  // tests need well under 1000 cycles; 4000 gives a wide margin
  initial begin
    #200_000;
    num_errors++;
    report_and_stop;
  end
endmodule : boot_image_loader_tb
`default_nettype wire

/* File: rtl/boot_image_loader.sv */
// start-up boot image loader: strap sampling, flash or uart image boot
// assumes uart bytes arrive as one-cycle strobes; flash fetch by request
`default_nettype none
// Notes on behaviour
// - two of the five strap pins (source, uart) choose the boot mode
// - two sources: flash image or uart image
// - flash boot reads image location first
// - first four bytes: ram address, range-checked
// - next four bytes: word length
// - zero or oversized length: error, restart
// - last four bytes: checksum compared
// - good sum launches, bad sum restarts
// - flash pins input at sampling, output during flash boot until launch
// - failures shown as code on leds
// - low flash-presence pin means no flash
// - uart disabled blocks code update
module boot_image_loader
  import boot_loader_pkg::*;
(
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_arst_n,
  // strap and flash-pin sensing
  input  wire logic [STRAP_WIDTH-1:0] i_strap,
  input  wire logic [1:0]             i_flash_pin_in,
  output logic      [1:0]             o_flash_pin_out,
  output logic      [1:0]             o_flash_pin_oe_n,
  // flash word fetch
  output logic                        o_flash_req,
  output logic      [31:0]            o_flash_addr,
  input  wire logic                   i_flash_ack,
  input  wire logic [31:0]            i_flash_data,
  // uart byte stream, 8n1 framing done outside
  input  wire logic                   i_rx_valid,
  input  wire logic [7:0]             i_rx_byte,
  output logic                        o_tx_valid,
  output logic      [7:0]             o_tx_byte,
  // internal_sync_ram write port
  output ram_write_t                  o_ram_wr,
  // status
  output logic      [2:0]             o_boot_led,
  output logic                        o_launch,
  output logic      [31:0]            o_launch_addr,
  output logic                        o_code_update_en
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  boot_state_t          state_q, state_d;
  logic [31:0]          shift_q, shift_d;
  logic [1:0]           bcnt_q, bcnt_d;
  logic [31:0]          dest_q, dest_d;
  logic [31:0]          words_q, words_d;
  logic [31:0]          wcnt_q, wcnt_d;
  logic [31:0]          sum_q, sum_d;
  logic [1:0]           pout_q, pout_d;
  logic [2:0]           led_q, led_d;
  logic                 tx_v_q, tx_v_d;
  logic [7:0]           tx_b_q, tx_b_d;
  ram_write_t           wr_q, wr_d;
  logic                 launch_q, launch_d;
  logic                 freq_q, freq_d;
  logic [31:0]          faddr_q, faddr_d;
  logic [1:0]           oe_n_q, oe_n_d;
  logic                 upd_q, upd_d;
  logic [31:0]          word_in;

  assign word_in = {shift_q[23:0], i_rx_byte};

  always_comb begin
    state_d  = state_q;
    shift_d  = shift_q;
    bcnt_d   = bcnt_q;
    dest_d   = dest_q;
    words_d  = words_q;
    wcnt_d   = wcnt_q;
    sum_d    = sum_q;
    // pins carry no data here; held low while driven
    pout_d   = 2'b00;
    led_d    = led_q;
    tx_v_d   = 1'b0;
    tx_b_d   = tx_b_q;
    wr_d     = wr_q;
    wr_d.valid = 1'b0;
    launch_d = launch_q;
    freq_d   = 1'b0;
    faddr_d  = faddr_q;
    oe_n_d   = oe_n_q;
    upd_d    = upd_q;
    if (i_rx_valid && state_q >= ST_U_ADDR && state_q <= ST_U_SUM) begin
      shift_d = word_in;
      bcnt_d  = bcnt_q + 2'h1;
    end
    case (state_q)
      // sample straps once, first cycle after reset
      ST_SAMPLE: begin
        bcnt_d  = 2'h0;
        // no uart means no code update
        upd_d   = i_strap[STRAP_UART_POS];
        if (i_strap[STRAP_SRC_POS]) begin
          if (!i_flash_pin_in[1]) begin
            led_d   = LED_NO_FLASH;
            state_d = ST_HALT;
          end else begin
            oe_n_d  = 2'b00;
            faddr_d = IMG_LOC_ADDR;
            freq_d  = 1'b1;
            state_d = ST_FL_LOC;
          end
        end else if (!i_strap[STRAP_UART_POS]) begin
          led_d   = LED_NO_UART;
          state_d = ST_HALT;
        end else begin
          state_d = ST_U_ADDR;
        end
      end
      ST_FL_LOC: begin
        freq_d = !i_flash_ack;
        if (i_flash_ack) begin
          dest_d  = RAM_LO;
          faddr_d = i_flash_data;
          wcnt_d  = 32'h0000_0000;
          freq_d  = 1'b1;
          state_d = ST_FL_IMG;
        end
      end
      // encrypted image copied as-is; decryption lies downstream
      ST_FL_IMG: begin
        freq_d = 1'b1;
        if (i_flash_ack) begin
          wr_d.valid = 1'b1;
          wr_d.addr  = dest_q + {wcnt_q[29:0], 2'b00};
          wr_d.data  = i_flash_data;
          wcnt_d     = wcnt_q + 32'h0000_0001;
          faddr_d    = faddr_q + 32'h0000_0004;
          if (wcnt_q == MAX_WORDS - 32'h0000_0001) begin
            freq_d  = 1'b0;
            state_d = ST_LAUNCH;
          end
        end
      end
      ST_U_ADDR: begin
        if (i_rx_valid && bcnt_q == FIELD_LAST[1:0]) begin
          dest_d = word_in;
          if (word_in < RAM_LO || word_in > RAM_HI) begin
            led_d   = LED_BAD_ADDR;
            tx_v_d  = 1'b1;
            tx_b_d  = ERR_ADDR_BYTE;
          end else begin
            state_d = ST_U_LEN;
          end
        end
      end
      ST_U_LEN: begin
        if (i_rx_valid && bcnt_q == FIELD_LAST[1:0]) begin
          words_d = word_in;
          wcnt_d  = 32'h0000_0000;
          sum_d   = 32'h0000_0000;
          if (word_in == 32'h0000_0000 || word_in > MAX_WORDS) begin
            led_d   = LED_BAD_LEN;
            tx_v_d  = 1'b1;
            tx_b_d  = ERR_LEN_BYTE;
            state_d = ST_U_ADDR;
          end else begin
            state_d = ST_U_DATA;
          end
        end
      end
      ST_U_DATA: begin
        if (i_rx_valid && bcnt_q == FIELD_LAST[1:0]) begin
          wr_d.valid = 1'b1;
          wr_d.addr  = dest_q + {wcnt_q[29:0], 2'b00};
          wr_d.data  = word_in;
          sum_d      = sum_q + word_in;
          wcnt_d     = wcnt_q + 32'h0000_0001;
          if (wcnt_q == words_q - 32'h0000_0001) begin
            state_d = ST_U_SUM;
          end
        end
      end
      ST_U_SUM: begin
        if (i_rx_valid && bcnt_q == FIELD_LAST[1:0]) begin
          // launch on match, restart on mismatch
          if (word_in == sum_q) begin
            led_d   = LED_OK;
            state_d = ST_LAUNCH;
          end else begin
            led_d   = LED_BAD_SUM;
            tx_v_d  = 1'b1;
            tx_b_d  = ERR_SUM_BYTE;
            state_d = ST_U_ADDR;
          end
        end
      end
      ST_LAUNCH: begin
        launch_d = 1'b1;
        oe_n_d   = 2'b11;
        state_d  = ST_HALT;
      end
      ST_HALT: begin
        state_d = ST_HALT;
      end
      default: begin
        state_d = ST_SAMPLE;
      end
    endcase
  end

  // reset release assumed after pll settles
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q  <= ST_SAMPLE;
      shift_q  <= 32'h0000_0000;
      bcnt_q   <= 2'h0;
      dest_q   <= 32'h0000_0000;
      words_q  <= 32'h0000_0000;
      wcnt_q   <= 32'h0000_0000;
      sum_q    <= 32'h0000_0000;
      pout_q   <= 2'b00;
      led_q    <= LED_OK;
      tx_v_q   <= 1'b0;
      tx_b_q   <= 8'h00;
      wr_q     <= '0;
      launch_q <= 1'b0;
      freq_q   <= 1'b0;
      faddr_q  <= 32'h0000_0000;
      oe_n_q   <= 2'b11;
      upd_q    <= 1'b0;
    end else begin
      state_q  <= state_d;
      shift_q  <= shift_d;
      bcnt_q   <= bcnt_d;
      dest_q   <= dest_d;
      words_q  <= words_d;
      wcnt_q   <= wcnt_d;
      sum_q    <= sum_d;
      pout_q   <= pout_d;
      led_q    <= led_d;
      tx_v_q   <= tx_v_d;
      tx_b_q   <= tx_b_d;
      wr_q     <= wr_d;
      launch_q <= launch_d;
      freq_q   <= freq_d;
      faddr_q  <= faddr_d;
      oe_n_q   <= oe_n_d;
      upd_q    <= upd_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // failure code on leds
  assign o_boot_led       = led_q;
  assign o_flash_pin_out  = pout_q;
  assign o_flash_pin_oe_n = oe_n_q;
  assign o_flash_req      = freq_q;
  assign o_flash_addr     = faddr_q;
  assign o_tx_valid       = tx_v_q;
  assign o_tx_byte        = tx_b_q;
  assign o_ram_wr         = wr_q;
  assign o_launch         = launch_q;
  assign o_launch_addr    = dest_q;
  assign o_code_update_en = upd_q;
endmodule : boot_image_loader
`default_nettype wire

/* File: rtl/boot_loader_pkg.sv */
// package for the start-up boot image loader
// assumes one 20 MHz clock and byte-wide uart receive/transmit strobes
`default_nettype none
package boot_loader_pkg;
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned STRAP_WIDTH     = 5;
  // strap bit positions
  localparam int unsigned STRAP_FLASH_POS = 0;
  localparam int unsigned STRAP_SRC_POS   = 1;
  localparam int unsigned STRAP_UART_POS  = 2;
  // sync ram window of the destination address
  localparam logic [31:0] RAM_LO          = 32'h0202_0000;
  localparam logic [31:0] RAM_HI          = 32'h0203_FFFF;
  // 128 kB expressed in 32-bit words
  localparam logic [31:0] MAX_WORDS       = 32'h0000_8000;
  localparam logic [31:0] IMG_LOC_ADDR    = 32'h0000_0000;
  localparam logic [2:0]  FIELD_LAST      = 3'h3;
  // error message bytes sent to the host
  localparam logic [7:0]  ERR_ADDR_BYTE   = 8'h41;
  localparam logic [7:0]  ERR_LEN_BYTE    = 8'h4C;
  localparam logic [7:0]  ERR_SUM_BYTE    = 8'h43;
  // led error codes
  localparam logic [2:0]  LED_OK          = 3'h0;
  localparam logic [2:0]  LED_NO_FLASH    = 3'h1;
  localparam logic [2:0]  LED_BAD_ADDR    = 3'h2;
  localparam logic [2:0]  LED_BAD_LEN     = 3'h3;
  localparam logic [2:0]  LED_BAD_SUM     = 3'h4;
  localparam logic [2:0]  LED_NO_UART     = 3'h5;

  typedef enum logic [3:0] {
    ST_SAMPLE   = 4'h0,
    ST_FL_LOC   = 4'h1,
    ST_FL_IMG   = 4'h2,
    ST_U_ADDR   = 4'h3,
    ST_U_LEN    = 4'h4,
    ST_U_DATA   = 4'h5,
    ST_U_SUM    = 4'h6,
    ST_LAUNCH   = 4'h7,
    ST_HALT     = 4'h8
  } boot_state_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [31:0] data;
  } ram_write_t;
endpackage : boot_loader_pkg
`default_nettype wire
